//--- src/msr_pkg.sv
// Shared constants and types of the meter serial record port
package msr_pkg;

  // Record and byte geometry
  localparam int unsigned REC_W       = 32;
  localparam int unsigned NUM_REC     = 8;
  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned BYTES_TOTAL = 32;
  localparam int unsigned PARITY_W    = 4;
  localparam int unsigned PARITY_POS  = 28;

  // Read bit counter: record(3) byte(2) bit(3)
  localparam int unsigned RD_CNT_W   = 8;
  localparam int unsigned FETCH_W    = 6;
  localparam logic [FETCH_W-1:0] FETCH_DONE = 6'h20;
  localparam logic [2:0]         SWAP_FLIP  = 3'h4;

  // Write command layout, value first then address then execute bit
  localparam int unsigned CMD_BITS   = 8;
  localparam int unsigned ADDR_W     = 6;
  localparam int unsigned CMD_VAL_POS = 6;
  localparam logic [2:0]  WR_LAST    = 3'h7;

  // Latch map: configuration bits at their number, mode bits from base upward
  localparam int unsigned CFG_BITS   = 56;
  localparam int unsigned MODE_BITS  = 8;
  localparam logic [ADDR_W-1:0] MODE_BASE = 6'h38;
  localparam int unsigned SWAP_MODE_IDX = 7;
  localparam int unsigned LSB_FIRST_CFG_IDX = 0;

  // Values after power-on reset
  localparam logic [CFG_BITS-1:0]  CFG_RST  = 56'h0;
  localparam logic [MODE_BITS-1:0] MODE_RST = 8'h00;

  // Positions of the synchronised pins
  localparam int unsigned PIN_SEL = 0;
  localparam int unsigned PIN_SYN = 1;
  localparam int unsigned PIN_SCK = 2;
  localparam int unsigned PIN_SDA = 3;
  localparam logic [3:0]  PIN_IDLE = 4'hF;

  // Output buffer depth
  localparam int unsigned FIFO_DEPTH = 2;

  // Port state, Gray along idle, read, write
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b11
  } msr_state_t;

endpackage

//--- src/msr_byte_if.sv
// Byte handshake between the record fetcher and the output buffer
`timescale 1ns/1ps
`default_nettype none
interface msr_byte_if;
  import msr_pkg::*;
  logic              flush;
  logic              push_valid;
  logic              push_ready;
  logic [BYTE_W-1:0] push_data;
  logic              pop_valid;
  logic              pop_ready;
  logic [BYTE_W-1:0] pop_data;

  modport user  (output flush, push_valid, push_data, pop_ready,
                 input  push_ready, pop_valid, pop_data);
  modport store (input  flush, push_valid, push_data, pop_ready,
                 output push_ready, pop_valid, pop_data);
endinterface
`default_nettype wire

//--- src/msr_byte_fifo.sv
// Two-entry byte buffer between record fetch and the bit shifter
`timescale 1ns/1ps
`default_nettype none
module msr_byte_fifo #(
  parameter int unsigned WIDTH = msr_pkg::BYTE_W,
  parameter int unsigned DEPTH = msr_pkg::FIFO_DEPTH
) (
  input  wire logic     clock_i,
  input  wire logic     rst_b_i,
  input  wire logic     clk_en_i,
  msr_byte_if.store     bus
);
  import msr_pkg::*;

  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PTR_W-1:0] wr_ptr_ff;
  logic [PTR_W-1:0] rd_ptr_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic             do_push;
  logic             do_pop;

  function automatic logic [PTR_W-1:0] next_ptr(input logic [PTR_W-1:0] p);
    next_ptr = (p == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(p + 1'b1);
  endfunction

  // Honest full and empty; a stalled shifter lets it fill and stops the fetcher
  assign bus.push_ready = (cnt_ff != CNT_W'(DEPTH));
  assign bus.pop_valid  = (cnt_ff != '0);
  assign bus.pop_data   = mem_ff[rd_ptr_ff];
  assign do_push = bus.push_valid && bus.push_ready && !bus.flush;
  assign do_pop  = bus.pop_valid && bus.pop_ready && !bus.flush;

  // Pointers and fill level; flush drops stale bytes after a counter reset
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end
    else if (clk_en_i)
    begin
      if (bus.flush)
      begin
        wr_ptr_ff <= '0;
        rd_ptr_ff <= '0;
        cnt_ff    <= '0;
      end
      else
      begin
        if (do_push)
          wr_ptr_ff <= next_ptr(wr_ptr_ff);
        if (do_pop)
          rd_ptr_ff <= next_ptr(rd_ptr_ff);
        if (do_push && !do_pop)
          cnt_ff <= CNT_W'(cnt_ff + 1'b1);
        else if (do_pop && !do_push)
          cnt_ff <= CNT_W'(cnt_ff - 1'b1);
      end
    end
  end

  // Storage, written only on an accepted push
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_ff[i] <= '0;
    end
    else if (clk_en_i && do_push)
      mem_ff[wr_ptr_ff] <= bus.push_data;
  end

  a_fifo_level_bound: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    cnt_ff <= CNT_W'(DEPTH))
    else $error("buffer level above depth");

  a_fifo_full_stall: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (cnt_ff == CNT_W'(DEPTH)) |-> !bus.push_ready)
    else $error("full buffer still accepts");

endmodule
`default_nettype wire

//--- src/msr_serial_port.sv
// Serial record port: latching, record shift-out and latch write commands
`timescale 1ns/1ps
`default_nettype none
module msr_serial_port (
  input  wire logic                                             clock_i,
  input  wire logic                                             rst_b_i,
  input  wire logic                                             clk_en_i,
  input  wire logic                                             port_select_n_i,
  input  wire logic                                             sync_strobe_i,
  input  wire logic                                             shift_clock_i,
  input  wire logic                                             shift_data_i,
  input  wire logic [msr_pkg::NUM_REC-1:0][msr_pkg::REC_W-1:0]  meas_record_i,
  output logic                                                  shift_data_o,
  output logic                                                  shift_data_oe_o,
  output logic [msr_pkg::CFG_BITS-1:0]                          config_o,
  output logic [msr_pkg::MODE_BITS-1:0]                         mode_o
);
  import msr_pkg::*;

  logic                               rst_meta_ff;
  logic                               rst_ff;
  logic [3:0]                         pin_meta_ff;
  logic [3:0]                         pin_sync_ff;
  logic                               sck_prev_ff;
  msr_state_t                         state_ff;
  msr_state_t                         nxt_state;
  logic [NUM_REC-1:0][REC_W-1:0]      latch_ff;
  logic [RD_CNT_W-1:0]                rd_cnt_ff;
  logic [FETCH_W-1:0]                 fetch_idx_ff;
  logic [BYTE_W-1:0]                  cur_byte_ff;
  logic                               have_byte_ff;
  logic [2:0]                         wr_cnt_ff;
  logic [CMD_BITS-2:0]                cmd_ff;
  logic [CFG_BITS-1:0]                cfg_ff;
  logic [MODE_BITS-1:0]               mode_ff;
  logic                               data_ff;
  logic                               data_oe_ff;
  logic                               sel_act;
  logic                               syn_hi;
  logic                               sck_rise;
  logic                               sck_fall;
  logic                               rd_clr;
  logic                               byte_end;
  logic                               wr_exec;
  logic [ADDR_W-1:0]                  wr_addr;
  logic                               wr_val;
  logic [CFG_BITS+MODE_BITS-1:0]      latch_all;
  msr_byte_if                         byte_bus ();

  // Replace the top nibble with interleaved parity of the 28 data bits
  // parity nibble
  function automatic logic [REC_W-1:0] with_parity(input logic [REC_W-1:0] raw);
    logic [PARITY_W-1:0] nib;
    nib = '0;
    for (int i = 0; i < PARITY_POS; i++)
      nib[i % PARITY_W] = nib[i % PARITY_W] ^ raw[i];
    with_parity = {nib, raw[PARITY_POS-1:0]};
  endfunction

  // Byte number n of the record set, honouring the swapped order
  function automatic logic [BYTE_W-1:0] record_byte(
    input logic [NUM_REC-1:0][REC_W-1:0] recs,
    input logic [FETCH_W-1:0]            n,
    input logic                          swap
  );
    logic [2:0]       rec;
    logic [REC_W-1:0] word;
    rec  = n[4:2] ^ (swap ? SWAP_FLIP : 3'h0);
    word = with_parity(recs[rec]);
    record_byte = word[n[1:0]*BYTE_W +: BYTE_W];
  endfunction

  // Bit of the current byte for the given position and order
  function automatic logic pick_bit(
    input logic [BYTE_W-1:0] b,
    input logic [2:0]        pos,
    input logic              lsb_first
  );
    pick_bit = lsb_first ? b[pos] : b[3'h7 - pos];
  endfunction

  // Reset asserts at once and releases after two clean edges
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rst_meta_ff <= 1'b0;
      rst_ff      <= 1'b0;
    end
    else if (clk_en_i)
    begin
      rst_meta_ff <= 1'b1;
      rst_ff      <= rst_meta_ff;
    end
  end

  // Two-stage pin synchronisers; pins rest high, so that is the reset value
  // idle pins high
  always_ff @(posedge clock_i or negedge rst_ff)
  begin
    if (!rst_ff)
    begin
      pin_meta_ff <= PIN_IDLE;
      pin_sync_ff <= PIN_IDLE;
      sck_prev_ff <= 1'b1;
    end
    else if (clk_en_i)
    begin
      pin_meta_ff <= {shift_data_i, shift_clock_i, sync_strobe_i, port_select_n_i};
      pin_sync_ff <= pin_meta_ff;
      sck_prev_ff <= pin_sync_ff[PIN_SCK];
    end
  end

  // Decoded pin levels and clock edges, falling edge is the leading one
  assign sel_act  = !pin_sync_ff[PIN_SEL];
  assign syn_hi   = pin_sync_ff[PIN_SYN];
  assign sck_rise = pin_sync_ff[PIN_SCK] && !sck_prev_ff;
  assign sck_fall = !pin_sync_ff[PIN_SCK] && sck_prev_ff;

  // Mode from select and sync; all high is idle
  // read or write
  always_comb
  begin
    if (!sel_act)
      nxt_state = ST_IDLE;
    else if (syn_hi)
      nxt_state = ST_READ;
    else
      nxt_state = ST_WRITE;
  end

  always_ff @(posedge clock_i or negedge rst_ff)
  begin
    if (!rst_ff)
      state_ff <= ST_IDLE;
    else if (clk_en_i)
      state_ff <= nxt_state;
  end

  // Sampling follows the sync pulse, last sample wins when it ends
  // latch on sync
  always_ff @(posedge clock_i or negedge rst_ff)
  begin
    if (!rst_ff)
      latch_ff <= '0;
    else if (clk_en_i && !sel_act && !syn_hi)
      latch_ff <= meas_record_i;
  end

  // Counter cleared on select entry or on sync held low into shifting
  // counter reset
  assign rd_clr   = sel_act && (state_ff == ST_IDLE || !syn_hi);
  assign byte_end = (state_ff == ST_READ) && sck_rise && (rd_cnt_ff[2:0] == 3'h7);

  // Wraps after eight records; the fetcher stops at byte 32, so a ninth record shifts out ones
  // counter advance
  always_ff @(posedge clock_i or negedge rst_ff)
  begin
    if (!rst_ff)
      rd_cnt_ff <= '0;
    else if (clk_en_i)
    begin
      if (rd_clr)
        rd_cnt_ff <= '0;
      else if (state_ff == ST_READ && sck_rise)
        rd_cnt_ff <= RD_CNT_W'(rd_cnt_ff + 1'b1);
    end
  end

  // Fetcher runs ahead of the shifter so a byte is ready at each boundary
  // low byte first
  assign byte_bus.flush      = rd_clr || (state_ff != ST_READ);
  assign byte_bus.push_valid = (state_ff == ST_READ) && (fetch_idx_ff != FETCH_DONE);
  assign byte_bus.push_data  = record_byte(latch_ff, fetch_idx_ff, mode_ff[SWAP_MODE_IDX]);
  assign byte_bus.pop_ready  = (state_ff == ST_READ) && !have_byte_ff;

  always_ff @(posedge clock_i or negedge rst_ff)
  begin
    if (!rst_ff)
      fetch_idx_ff <= '0;
    else if (clk_en_i)
    begin
      if (byte_bus.flush)
        fetch_idx_ff <= '0;
      else if (byte_bus.push_valid && byte_bus.push_ready)
        fetch_idx_ff <= FETCH_W'(fetch_idx_ff + 1'b1);
    end
  end

  msr_byte_fifo u_byte_fifo (
    .clock_i  (clock_i),
    .rst_b_i  (rst_ff),
    .clk_en_i (clk_en_i),
    .bus      (byte_bus)
  );

  // Byte under shift; dropped at its last trailing edge, refilled from the buffer
  always_ff @(posedge clock_i or negedge rst_ff)
  begin
    if (!rst_ff)
    begin
      cur_byte_ff  <= '0;
      have_byte_ff <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (byte_bus.flush || byte_end)
        have_byte_ff <= 1'b0;
      else if (byte_bus.pop_valid && byte_bus.pop_ready)
      begin
        cur_byte_ff  <= byte_bus.pop_data;
        have_byte_ff <= 1'b1;
      end
    end
  end

  // Pin driver; the bit moves only after a trailing edge bumped the counter
  // trailing edge update
  always_ff @(posedge clock_i or negedge rst_ff)
  begin
    if (!rst_ff)
      data_ff <= 1'b1;
    else if (clk_en_i)
    begin
      case (state_ff)
        ST_READ:
          // Deselect or a sync drop forces the idle level now, not one cycle late
          data_ff <= (sel_act && syn_hi && have_byte_ff)
                     ? pick_bit(cur_byte_ff, rd_cnt_ff[2:0], cfg_ff[LSB_FIRST_CFG_IDX]) : 1'b1;
        default:
          data_ff <= 1'b1;
      endcase
    end
  end

  // Driver enabled only in read mode; low sync turns the pin into an input
  // driver off in write
  always_ff @(posedge clock_i or negedge rst_ff)
  begin
    if (!rst_ff)
      data_oe_ff <= 1'b0;
    else if (clk_en_i)
      data_oe_ff <= (nxt_state == ST_READ);
  end

  // Command fields after seven data edges
  // command layout
  assign wr_val  = cmd_ff[CMD_VAL_POS];
  assign wr_addr = cmd_ff[ADDR_W-1:0];
  // Execute only while write mode still holds, so a deselect never races the swap clear
  assign wr_exec = (state_ff == ST_WRITE) && (nxt_state == ST_WRITE) && sck_fall && (wr_cnt_ff == WR_LAST);

  // Data sampled at the leading edge; the count restarts on each write period
  // command strings
  always_ff @(posedge clock_i or negedge rst_ff)
  begin
    if (!rst_ff)
    begin
      wr_cnt_ff <= '0;
      cmd_ff    <= '0;
    end
    else if (clk_en_i)
    begin
      if (state_ff != ST_WRITE)
        wr_cnt_ff <= '0;
      else if (sck_fall)
      begin
        wr_cnt_ff <= (wr_cnt_ff == WR_LAST) ? 3'h0 : 3'(wr_cnt_ff + 1'b1);
        if (wr_cnt_ff != WR_LAST)
          cmd_ff <= {cmd_ff[CMD_BITS-3:0], pin_sync_ff[PIN_SDA]};
      end
    end
  end

  // Configuration latches, cleared by power-on reset or bit by bit by a write of value 0
  // execute stores value
  always_ff @(posedge clock_i or negedge rst_ff)
  begin
    if (!rst_ff)
      cfg_ff <= CFG_RST;
    else if (clk_en_i && wr_exec && wr_addr < MODE_BASE)
      cfg_ff[wr_addr] <= wr_val;
  end

  // Mode latches; the swap bit lives only until select is released
  // swap not retained
  always_ff @(posedge clock_i or negedge rst_ff)
  begin
    if (!rst_ff)
      mode_ff <= MODE_RST;
    else if (clk_en_i)
    begin
      if (wr_exec && wr_addr >= MODE_BASE)
        mode_ff[wr_addr[2:0]] <= wr_val;
      else if (!sel_act)
        mode_ff[SWAP_MODE_IDX] <= 1'b0;
    end
  end

  assign shift_data_o    = data_ff;
  assign shift_data_oe_o = data_oe_ff;
  assign config_o        = cfg_ff;
  assign mode_o          = mode_ff;
  assign latch_all       = {mode_ff, cfg_ff};

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_ff);

  a_latch_on_sync: assert property (
    (clk_en_i && !sel_act && !syn_hi) |=> (latch_ff == $past(meas_record_i)))
    else $error("records not latched on sync");

  a_cnt_clear: assert property (
    (clk_en_i && sel_act && !syn_hi) |=> (rd_cnt_ff == '0))
    else $error("shift counter not cleared");

  a_cnt_advance: assert property (
    (clk_en_i && state_ff == ST_READ && sel_act && syn_hi && sck_rise)
      |=> (rd_cnt_ff == RD_CNT_W'($past(rd_cnt_ff) + 8'h01)))
    else $error("shift counter did not advance");

  a_abort_release: assert property (
    (clk_en_i && !sel_act) |=> (!shift_data_oe_o && shift_data_o))
    else $error("pin still driven after deselect");

  a_write_release: assert property (
    (clk_en_i && sel_act && !syn_hi) |=> !shift_data_oe_o)
    else $error("pin driven in write mode");

  a_read_drive: assert property (
    (clk_en_i && sel_act && syn_hi) |=> shift_data_oe_o)
    else $error("pin not driven in read mode");

  a_exec_store: assert property (
    (clk_en_i && wr_exec) |=> (latch_all[$past(wr_addr)] == $past(wr_val)))
    else $error("execute bit did not store value");

  a_swap_dropped: assert property (
    (clk_en_i && !sel_act) |=> !mode_o[SWAP_MODE_IDX])
    else $error("swap request retained");

  a_bit_hold: assert property (
    (clk_en_i && state_ff == ST_READ && $stable(rd_cnt_ff) && $stable(cur_byte_ff)
      && $stable(have_byte_ff) && nxt_state == ST_READ) |=> $stable(shift_data_o))
    else $error("data moved without a trailing edge");

endmodule
`default_nettype wire

//--- bench/msr_host_model.sv
// Host side model driving select, sync, shift clock and the shared data pin
`timescale 1ns/1ps
`default_nettype none
module msr_host_model #(
  parameter int WR_HALF = 204
) (
  input  wire logic clock_i,
  input  wire logic sda_i,
  output var  logic sel_n_o,
  output var  logic sync_o,
  output var  logic sck_o,
  output var  logic sda_o,
  output var  logic sda_oe_o
);
  // idle all high
  // Pins start released; the pull-up in the bench holds the data wire high
  initial
  begin
    sel_n_o  = 1'b1;
    sync_o   = 1'b1;
    sck_o    = 1'b1;
    sda_o    = 1'b1;
    sda_oe_o = 1'b0;
  end

  // Every task starts right after a rising clock edge and ends on one
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  task automatic latch();
    sync_o <= 1'b0;
    cyc(8);
    sync_o <= 1'b1;
    cyc(8);
  endtask

  task automatic open(input logic wr);
    sync_o <= ~wr;
    // Write entry holds sync over 1 us first, as a swap sequence needs
    cyc(wr ? 48 : 2);
    sel_n_o <= 1'b0;
    cyc(8);
  endtask

  task automatic pulse();
    sync_o <= 1'b0;
    cyc(3);
    sync_o <= 1'b1;
    cyc(8);
  endtask

  task automatic deselect();
    sel_n_o  <= 1'b1;
    sda_oe_o <= 1'b0;
    cyc(1);
  endtask

  task automatic sync_hi();
    sda_oe_o <= 1'b0;
    sync_o   <= 1'b1;
    cyc(8);
  endtask

  task automatic close();
    deselect();
    sync_o <= 1'b1;
    cyc(8);
  endtask

  // command bits, slow clock
  // Data only moves right after a trailing edge, so the leading edge sees it settled
  task automatic send(input logic [7:0] b, input int nbits);
    for (int i = 0; i < nbits; i++)
    begin
      sda_o    <= b[7-i];
      sda_oe_o <= 1'b1;
      cyc(WR_HALF);
      sck_o <= 1'b0;
      cyc(WR_HALF);
      sck_o <= 1'b1;
    end
    cyc(1);
  endtask

  // shift only, sample late
  // Sampled at a falling clock edge, away from the device's register updates
  task automatic recv(input int n, output logic [255:0] q);
    q = '0;
    for (int i = 0; i < n; i++)
    begin
      sck_o <= 1'b0;
      cyc(3);
      @(negedge clock_i);
      q[i] = sda_i;
      cyc(1);
      sck_o <= 1'b1;
      cyc(4);
    end
  endtask
endmodule
`default_nettype wire

//--- bench/msr_serial_port_tb.sv
// Self-checking bench of the serial record port against the host model
`timescale 1ns/1ps
`default_nettype none
module msr_serial_port_tb;
  import msr_pkg::*;
  logic                          clock_i;
  logic                          rst_b_i;
  logic                          clk_en;
  logic [NUM_REC-1:0][REC_W-1:0] meas;
  logic [NUM_REC-1:0][REC_W-1:0] lat;
  logic                          sel_n;
  logic                          sync_s;
  logic                          sck;
  logic                          h_sda;
  logic                          h_oe;
  logic                          d_sda;
  logic                          d_oe;
  logic                          sda;
  logic [CFG_BITS-1:0]           cfg;
  logic [MODE_BITS-1:0]          mode;
  logic [CFG_BITS-1:0]           ecfg;
  int                            err_count;
  int                            comparisons;

  // Shared pin: whoever enables drives, otherwise the weak pull-up wins
  assign sda = d_oe ? d_sda : (h_oe ? h_sda : 1'b1);

  msr_serial_port DUT (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en), .port_select_n_i(sel_n),
    .sync_strobe_i(sync_s), .shift_clock_i(sck), .shift_data_i(sda), .meas_record_i(meas),
    .shift_data_o(d_sda), .shift_data_oe_o(d_oe), .config_o(cfg), .mode_o(mode)
  );

  msr_host_model host (
    .clock_i(clock_i), .sda_i(sda), .sel_n_o(sel_n), .sync_o(sync_s),
    .sck_o(sck), .sda_o(h_sda), .sda_oe_o(h_oe)
  );

  // 40 MHz clock
  initial
  begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Record as sent: top nibble replaced by interleaved parity of the data bits
  function automatic logic [31:0] with_par(input logic [31:0] r);
    logic [31:0] v;
    v = r;
    for (int k = 0; k < 4; k++)
    begin
      v[28+k] = 1'b0;
      for (int i = k; i < 28; i += 4)
        v[28+k] ^= r[i];
    end
    return v;
  endfunction

  // Wire order: low byte first, bits of a byte by the order switch
  function automatic logic [31:0] stream(input logic [31:0] r, input logic lsb);
    logic [31:0] s;
    for (int j = 0; j < 32; j++)
      s[j] = lsb ? r[8*(j/8) + j%8] : r[8*(j/8) + 7 - j%8];
    return s;
  endfunction

  task automatic judge(input logic [255:0] q, input int n, input logic swp);
    int r;
    for (int k = 0; k < n; k++)
    begin
      r = swp ? (k + 4) % 8 : k;
      chk("record", q[32*k +: 32], stream(with_par(lat[r]), ecfg[LSB_FIRST_CFG_IDX]));
    end
  endtask

  task automatic rd_chk(input int n);
    logic [255:0] q;
    host.open(1'b0);
    host.recv(32*n, q);
    host.close();
    judge(q, n, 1'b0);
  endtask

  task automatic do_latch();
    host.latch();
    lat = meas;
  endtask

  task automatic s_reset();
    chk("oe", d_oe, 1'b0);
    chk("data", d_sda, 1'b1);
    chk("config", cfg, '0);
    chk("mode", mode, '0);
  endtask

  // Full eight-record read, then shifting repeated without a new latch
  task automatic s_read();
    do_latch();
    rd_chk(8);
    for (int r = 0; r < NUM_REC; r++)
      meas[r] <= ~meas[r];
    host.cyc(1);
    // Frozen clock enable: the port must not see this latch pulse
    clk_en <= 1'b0;
    host.latch();
    clk_en <= 1'b1;
    host.cyc(4);
    rd_chk(2);
  endtask

  // Select dropped mid-record, next read starts again at bit zero
  task automatic s_abort();
    logic [255:0] q;
    int           n;
    host.open(1'b0);
    host.recv(12, q);
    host.deselect();
    n = 0;
    while (d_oe !== 1'b0 && n < 8)
    begin
      @(negedge clock_i);
      n++;
    end
    chk("abort oe", d_oe, 1'b0);
    if (n >= 8)
      close_out();
    @(posedge clock_i);
    host.close();
    rd_chk(1);
    // Short sync pulse mid-record clears the counter; the record restarts whole
    host.open(1'b0);
    host.recv(12, q);
    host.pulse();
    host.recv(32, q);
    host.close();
    judge(q, 1, 1'b0);
  endtask

  // Power-on reset mid-run clears every latch, the bit order with it
  task automatic s_por();
    ecfg     = '0;
    rst_b_i <= 1'b0;
    host.cyc(2);
    rst_b_i <= 1'b1;
    host.cyc(8);
    s_reset();
    do_latch();
    rd_chk(1);
  endtask

  // Commands back to back, a torn command, then an LSB-first read
  task automatic s_write();
    host.open(1'b1);
    host.send(8'h80, 8);
    ecfg[0] = 1'b1;
    chk("cfg bit 0", cfg, ecfg);
    host.send(8'hDF, 8);
    ecfg[47] = 1'b1;
    chk("cfg bit 47", cfg, ecfg);
    host.send(8'h5E, 8);
    ecfg[47] = 1'b0;
    chk("cfg clear 47", cfg, ecfg);
    host.send(8'hF9, 8);
    chk("mode bit 4", mode, 8'h10);
    host.send(8'hBF, 4);
    host.close();
    chk("torn cmd", cfg, ecfg);
    do_latch();
    rd_chk(2);
  endtask

  // Swap request sent in the same select period as the read, then forgotten
  task automatic s_swap();
    logic [255:0] q;
    do_latch();
    host.open(1'b1);
    host.send(8'hFF, 8);
    chk("swap set", mode, 8'h90);
    host.sync_hi();
    host.recv(256, q);
    host.close();
    judge(q, 8, 1'b1);
    chk("swap gone", mode, 8'h10);
    rd_chk(1);
  endtask

  // Main sequence
  initial
  begin
    err_count   = 0;
    comparisons = 0;
    ecfg        = '0;
    clk_en      = 1'b1;
    rst_b_i     = 1'b0;
    for (int r = 0; r < NUM_REC; r++)
      meas[r] = 32'h5AC3_96E1 ^ (32'(r) * 32'h0F0F_1111);
    lat = meas;
    repeat (2) @(posedge clock_i);
    rst_b_i <= 1'b1;
    host.cyc(8);
    s_reset();
    s_read();
    s_abort();
    s_write();
    s_swap();
    s_por();
    close_out();
  end
endmodule
`default_nettype wire
